//--- src/nccr_pkg.sv
// Purpose: constants shared by the oscillator and channel register slice
// Assumes: byte-wide registers behind a three-wire serial port
// Notes:   all offsets are serial-port register addresses
package nccr_pkg;
	// register addresses
	localparam logic [4:0] ADDR_FREQ_B2  = 5'h05;
	localparam logic [4:0] ADDR_FREQ_B3  = 5'h06;
	localparam logic [4:0] ADDR_PHASE_B0 = 5'h07;
	localparam logic [4:0] ADDR_PHASE_B1 = 5'h08;
	localparam logic [4:0] ADDR_CHA_CFG1 = 5'h09;
	localparam logic [4:0] ADDR_CHA_CFG2 = 5'h0A;
	localparam logic [4:0] ADDR_CHA_CFG3 = 5'h0B;
	localparam logic [4:0] ADDR_CHB_CFG1 = 5'h0C;
	localparam logic [4:0] ADDR_CHB_CFG2 = 5'h0D;
	localparam logic [4:0] ADDR_CHB_CFG3 = 5'h0E;
	localparam logic [4:0] ADDR_FIRST    = ADDR_FREQ_B2;
	localparam logic [4:0] ADDR_LAST     = ADDR_CHB_CFG3;
	localparam int         REG_COUNT     = 10;

	// value of every register after reset
	localparam logic [7:0] REG_RESET     = 8'h00;

	// field positions inside a byte
	localparam int POWER_OFF_BIT  = 7;
	localparam int SLEEP_BIT      = 6;
	localparam int COARSE_MSB     = 7;
	localparam int COARSE_LSB     = 6;
	localparam int LOW6_MSB       = 5;
	localparam int LOW6_LSB       = 0;

	// low-power oscillator keeps this many top bits of a word byte
	localparam int LP_KEEP_BITS   = 5;

	// serial frame layout: command byte then data byte, msb first
	localparam int          CMD_READ_BIT = 7;
	localparam int          ADDR_MSB     = 4;
	localparam logic [2:0]  LAST_BIT     = 3'h7;
	localparam logic [2:0]  CNT_RESET    = 3'h0;
	localparam logic [7:0]  SHIFT_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET   = 16'h0000;

	// serial frame states, gray coded along the path
	typedef enum logic [1:0]
	{
		NCCR_IDLE = 2'b00,
		NCCR_CMD  = 2'b01,
		NCCR_DATA = 2'b11,
		NCCR_DONE = 2'b10
	} nccr_state_e;
endpackage

//--- src/nccr_top.sv
// Purpose: oscillator word and per-channel configuration registers
// Assumes: serial clock, select and data come from outside, unsynchronised
// Notes:   serial clock must be slow against clock, see hand-over timing
`timescale 1ns/100ps
module nccr_top
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sdio_in,
	output logic             spi_sdio_out,
	output logic             spi_sdio_oe,
	input  wire logic        osc_low_power_select,
	output logic [15:0]      osc_frequency_word_hi,
	output logic [15:0]      osc_phase_word,
	output logic             chan_a_power_off,
	output logic             chan_a_sleep,
	output logic [11:0]      chan_a_offset,
	output logic [3:0]       chan_a_gain_coarse,
	output logic [5:0]       chan_a_gain_fine,
	output logic             chan_b_power_off,
	output logic             chan_b_sleep,
	output logic [11:0]      chan_b_offset,
	output logic [3:0]       chan_b_gain_coarse,
	output logic [5:0]       chan_b_gain_fine
);

	// register storage, index is address minus first address
	logic [7:0]              regs_q [0:nccr_pkg::REG_COUNT-1];
	logic [7:0]              regs_d [0:nccr_pkg::REG_COUNT-1];

	// synchroniser stages for the three serial inputs
	logic                    sclk_s1_q;
	logic                    sclk_s2_q;
	logic                    sclk_s3_q;
	logic                    cs_s1_q;
	logic                    cs_s2_q;
	logic                    sdi_s1_q;
	logic                    sdi_s2_q;

	// serial frame state
	nccr_pkg::nccr_state_e   state_q;
	nccr_pkg::nccr_state_e   state_d;
	logic [2:0]              cnt_q;
	logic [2:0]              cnt_d;
	logic [7:0]              shift_q;
	logic [7:0]              shift_d;
	logic                    rd_q;
	logic                    rd_d;
	logic [4:0]              addr_q;
	logic [4:0]              addr_d;
	logic                    sdo_q;
	logic                    sdo_d;
	logic                    oe_q;
	logic                    oe_d;

	// oscillator output words
	logic [15:0]             freq_q;
	logic [15:0]             freq_d;
	logic [15:0]             phase_q;
	logic [15:0]             phase_d;

	logic                    sclk_rise;
	logic                    sclk_fall;
	logic [7:0]              byte_in;

	// true when an address falls inside this slice
	function automatic logic in_range(input logic [4:0] a);
		in_range = (a >= nccr_pkg::ADDR_FIRST) && (a <= nccr_pkg::ADDR_LAST);
	endfunction

	// array index of an address, only meaningful when in range
	function automatic logic [3:0] reg_index(input logic [4:0] a);
		logic [4:0] diff;
		diff = a - nccr_pkg::ADDR_FIRST;
		reg_index = diff[3:0];
	endfunction

	// full word, or only the top bits of the upper byte in low power
	function automatic logic [15:0] lp_word(input logic lp,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [15:0] full;
		logic [15:0] mask;
		full = {hi, lo};
		mask = {{nccr_pkg::LP_KEEP_BITS{1'b1}},
			{(16 - nccr_pkg::LP_KEEP_BITS){1'b0}}};
		lp_word = lp ? (full & mask) : full;
	endfunction

	// two flops per input before any logic looks at it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			sdi_s1_q  <= 1'b0;
			sdi_s2_q  <= 1'b0;
		end
		else
		begin
			sclk_s1_q <= spi_sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_s1_q   <= spi_cs_n;
			cs_s2_q   <= cs_s1_q;
			sdi_s1_q  <= spi_sdio_in;
			sdi_s2_q  <= sdi_s1_q;
		end
	end

	// edges seen on the synchronised serial clock only
	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
	assign byte_in   = {shift_q[6:0], sdi_s2_q};

	// serial frame: command byte, then one data byte per frame
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		rd_d    = rd_q;
		addr_d  = addr_q;
		sdo_d   = sdo_q;
		oe_d    = oe_q;
		for (int i = 0; i < nccr_pkg::REG_COUNT; i++)
		begin
			regs_d[i] = regs_q[i];
		end
		if (cs_s2_q)
		begin
			// select high aborts any frame, a partial write is dropped
			state_d = nccr_pkg::NCCR_IDLE;
			cnt_d   = nccr_pkg::CNT_RESET;
			oe_d    = 1'b0;
		end
		else
		begin
			unique case (state_q)
				nccr_pkg::NCCR_IDLE:
				begin
					state_d = nccr_pkg::NCCR_CMD;
					cnt_d   = nccr_pkg::CNT_RESET;
				end
				nccr_pkg::NCCR_CMD:
				begin
					if (sclk_rise)
					begin
						shift_d = byte_in;
						cnt_d   = cnt_q + 3'h1;
						if (cnt_q == nccr_pkg::LAST_BIT)
						begin
							rd_d    = byte_in[nccr_pkg::CMD_READ_BIT];
							addr_d  = byte_in[nccr_pkg::ADDR_MSB:0];
							state_d = nccr_pkg::NCCR_DATA;
							cnt_d   = nccr_pkg::CNT_RESET;
							// reads return stored bytes, zero elsewhere
							if (in_range(byte_in[nccr_pkg::ADDR_MSB:0]))
							begin
								shift_d = regs_q[reg_index(
									byte_in[nccr_pkg::ADDR_MSB:0])];
							end
							else
							begin
								shift_d = nccr_pkg::SHIFT_RESET;
							end
						end
					end
				end
				nccr_pkg::NCCR_DATA:
				begin
					if (rd_q && sclk_fall)
					begin
						// host samples each bit on the next rising edge
						sdo_d   = shift_q[7];
						oe_d    = 1'b1;
						shift_d = {shift_q[6:0], 1'b0};
					end
					if (sclk_rise)
					begin
						cnt_d = cnt_q + 3'h1;
						if (!rd_q)
						begin
							shift_d = byte_in;
						end
						if (cnt_q == nccr_pkg::LAST_BIT)
						begin
							state_d = nccr_pkg::NCCR_DONE;
							oe_d    = 1'b0;
							// each address stores all eight bits alone
							if (!rd_q && in_range(addr_q))
							begin
								regs_d[reg_index(addr_q)] = byte_in;
							end
						end
					end
				end
				nccr_pkg::NCCR_DONE:
				begin
					// extra clocks in the same frame are ignored
					state_d = nccr_pkg::NCCR_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= nccr_pkg::NCCR_IDLE;
			cnt_q   <= nccr_pkg::CNT_RESET;
			shift_q <= nccr_pkg::SHIFT_RESET;
			rd_q    <= 1'b0;
			addr_q  <= 5'h00;
			sdo_q   <= 1'b0;
			oe_q    <= 1'b0;
			for (int i = 0; i < nccr_pkg::REG_COUNT; i++)
			begin
				regs_q[i] <= nccr_pkg::REG_RESET;
			end
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			rd_q    <= rd_d;
			addr_q  <= addr_d;
			sdo_q   <= sdo_d;
			oe_q    <= oe_d;
			for (int i = 0; i < nccr_pkg::REG_COUNT; i++)
			begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	// oscillator words, one cycle behind a write or a mode change
	always_comb
	begin
		freq_d  = lp_word(osc_low_power_select,
			regs_q[reg_index(nccr_pkg::ADDR_FREQ_B3)],
			regs_q[reg_index(nccr_pkg::ADDR_FREQ_B2)]);
		phase_d = lp_word(osc_low_power_select,
			regs_q[reg_index(nccr_pkg::ADDR_PHASE_B1)],
			regs_q[reg_index(nccr_pkg::ADDR_PHASE_B0)]);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			freq_q  <= nccr_pkg::WORD_RESET;
			phase_q <= nccr_pkg::WORD_RESET;
		end
		else
		begin
			freq_q  <= freq_d;
			phase_q <= phase_d;
		end
	end

	assign osc_frequency_word_hi = freq_q;
	assign osc_phase_word        = phase_q;
	assign spi_sdio_out          = sdo_q;
	assign spi_sdio_oe           = oe_q;

	// channel A fields, straight from the register flops
	assign chan_a_power_off = regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG1)]
		[nccr_pkg::POWER_OFF_BIT];
	assign chan_a_sleep = regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG1)]
		[nccr_pkg::SLEEP_BIT];
	assign chan_a_offset = {
		regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG3)]
			[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB],
		regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG1)]
			[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB]};
	assign chan_a_gain_coarse = {
		regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG3)]
			[nccr_pkg::COARSE_MSB:nccr_pkg::COARSE_LSB],
		regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG2)]
			[nccr_pkg::COARSE_MSB:nccr_pkg::COARSE_LSB]};
	assign chan_a_gain_fine = regs_q[reg_index(nccr_pkg::ADDR_CHA_CFG2)]
		[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB];

	// channel B fields, same layout one block higher
	assign chan_b_power_off = regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG1)]
		[nccr_pkg::POWER_OFF_BIT];
	assign chan_b_sleep = regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG1)]
		[nccr_pkg::SLEEP_BIT];
	assign chan_b_offset = {
		regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG3)]
			[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB],
		regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG1)]
			[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB]};
	assign chan_b_gain_coarse = {
		regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG3)]
			[nccr_pkg::COARSE_MSB:nccr_pkg::COARSE_LSB],
		regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG2)]
			[nccr_pkg::COARSE_MSB:nccr_pkg::COARSE_LSB]};
	assign chan_b_gain_fine = regs_q[reg_index(nccr_pkg::ADDR_CHB_CFG2)]
		[nccr_pkg::LOW6_MSB:nccr_pkg::LOW6_LSB];

endmodule

//--- bench/nccr_top_asserts.sv
// Purpose: port-level checks of the oscillator and channel registers
// Assumes: host keeps each sclk phase at least 8 clocks long
// Notes:   sees only the ports of nccr_top; bound after the module
`timescale 1ns/100ps
module nccr_checker
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        spi_sclk,
	input wire logic        spi_cs_n,
	input wire logic        spi_sdio_in,
	input wire logic        spi_sdio_out,
	input wire logic        spi_sdio_oe,
	input wire logic        osc_low_power_select,
	input wire logic [15:0] osc_frequency_word_hi,
	input wire logic [15:0] osc_phase_word,
	input wire logic        chan_a_power_off,
	input wire logic        chan_a_sleep,
	input wire logic [11:0] chan_a_offset,
	input wire logic [3:0]  chan_a_gain_coarse,
	input wire logic [5:0]  chan_a_gain_fine,
	input wire logic        chan_b_power_off,
	input wire logic        chan_b_sleep,
	input wire logic [11:0] chan_b_offset,
	input wire logic [3:0]  chan_b_gain_coarse,
	input wire logic [5:0]  chan_b_gain_fine
);
	logic [3:0] idle_q;
	logic [3:0] idle_d;
	// cycles with select high, saturating so it never wraps
	always_comb
	begin
		idle_d = idle_q;
		if (!spi_cs_n && (idle_q != 4'hF))
			idle_d = idle_q;
		if (!spi_cs_n)
			idle_d = 4'h0;
		else if (idle_q != 4'hF)
			idle_d = idle_q + 4'h1;
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			idle_q <= 4'h0;
		else
			idle_q <= idle_d;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_reset_clear: assert property ($rose(rst_n)
		|-> !spi_sdio_oe && chan_a_offset == 12'h000
		&& chan_b_gain_fine == 6'h00 && osc_frequency_word_hi == 16'h0000)
		else $error("outputs not cleared by reset");
	a_oe_idle: assert property (idle_q >= 4'h8 |-> !spi_sdio_oe)
		else $error("sdio driven outside a frame");
	a_oe_rise_low: assert property ($rose(spi_sdio_oe)
		|-> !spi_cs_n && !spi_sclk)
		else $error("sdio driven while sclk high");
	a_read_bit_hold: assert property (
		spi_sdio_oe && $changed(spi_sdio_out)
		|-> $past(spi_sclk, 2) == 1'b0)
		else $error("read bit moved late");
	a_cha_hold: assert property (idle_q >= 4'h8
		|-> $stable({chan_a_power_off, chan_a_sleep, chan_a_offset,
		chan_a_gain_coarse, chan_a_gain_fine}))
		else $error("channel a changed without a write");
	a_chb_hold: assert property (idle_q >= 4'h8
		|-> $stable({chan_b_power_off, chan_b_sleep, chan_b_offset,
		chan_b_gain_coarse, chan_b_gain_fine}))
		else $error("channel b changed without a write");
	a_osc_hold: assert property (idle_q >= 4'h8
		&& $stable(osc_low_power_select)
		|=> $stable({osc_frequency_word_hi, osc_phase_word}))
		else $error("oscillator word changed without a write");
	a_lp_freq_mask: assert property (osc_low_power_select |=>
		osc_frequency_word_hi[10:0] == 11'h000)
		else $error("freq not masked");
	a_lp_phase_mask: assert property (osc_low_power_select |=>
		osc_phase_word[10:0] == 11'h000)
		else $error("phase not masked");
	c_read: cover property ($rose(spi_sdio_oe));
	c_power: cover property ($rose(chan_a_power_off));
	c_lp: cover property (osc_low_power_select ##1 osc_phase_word != 16'h0000);
endmodule
bind nccr_top nccr_checker chk_u (.clock, .rst_n, .spi_sclk, .spi_cs_n,
	.spi_sdio_in, .spi_sdio_out, .spi_sdio_oe, .osc_low_power_select,
	.osc_frequency_word_hi, .osc_phase_word, .chan_a_power_off, .chan_a_sleep,
	.chan_a_offset, .chan_a_gain_coarse, .chan_a_gain_fine, .chan_b_power_off,
	.chan_b_sleep, .chan_b_offset, .chan_b_gain_coarse, .chan_b_gain_fine);

//--- bench/nccr_host.sv
// Purpose: serial host that writes and reads one register per frame
// Assumes: sclk idles high, each phase 10 clocks, select gaps 6 clocks
// Notes:   a released data line toggles so stale bits never look valid
`timescale 1ns/100ps
module nccr_host
(
	input wire logic   clock,
	input wire logic   sdio_wire,
	output logic       sclk,
	output logic       cs_n,
	output logic       sdo,
	output logic       done,
	output logic [7:0] rdata
);
	logic drv;
	logic dat;
	logic rel;
	// one driver for sdo, so the frame task never races the toggler
	assign sdo = drv ? dat : rel;
	initial
	begin
		{sclk, cs_n, dat, rel, done, drv, rdata} = {5'b11000, 1'b0, 8'h00};
	end
	// released line shows a changing pattern
	always @(posedge clock)
	begin
		rel <= ~rel;
	end
	// n below 16 cuts the frame early, only used for writes
	task automatic frame(input logic rd, input logic [4:0] a,
		input logic [7:0] d, input int n);
		logic [15:0] w;
		logic [7:0]  q;
		w = {rd, 2'b00, a, d};
		q = 8'h00;
		@(posedge clock);
		cs_n <= 1'b0;
		repeat (6) @(posedge clock);
		for (int i = 15; i > 15 - n; i--)
		begin
			sclk <= 1'b0;
			drv <= !(rd && i < 8);
			dat <= w[i];
			repeat (10) @(posedge clock);
			sclk <= 1'b1;
			if (i < 8)
				q[i] = sdio_wire;
			repeat (10) @(posedge clock);
		end
		{cs_n, drv, done, rdata} <= {2'b10, rd, q};
		@(posedge clock);
		done <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
endmodule

//--- bench/nccr_tb.sv
// Purpose: self-checking bench for the oscillator and channel registers
// Assumes: host model frames, reads checked from a queue of expectations
// Notes:   register image img mirrors every accepted write
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic       clock;
	logic       rst_n;
	logic       lp;
	logic       sclk;
	logic       cs_n;
	logic       hsdo;
	logic       done;
	logic       sdio_w;
	logic [7:0] rdata;
	logic [7:0] e_v;
	logic [7:0] img [5:14];
	logic [7:0] exp_q [$];
	int         failures;
	int         tests_run;
	assign sdio_w = dut_u.spi_sdio_oe ? dut_u.spi_sdio_out : hsdo;
	nccr_top dut_u (.clock(clock), .rst_n(rst_n), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .spi_sdio_in(sdio_w), .spi_sdio_out(),
		.spi_sdio_oe(), .osc_low_power_select(lp), .osc_frequency_word_hi(),
		.osc_phase_word(), .chan_a_power_off(), .chan_a_sleep(),
		.chan_a_offset(), .chan_a_gain_coarse(), .chan_a_gain_fine(),
		.chan_b_power_off(), .chan_b_sleep(), .chan_b_offset(),
		.chan_b_gain_coarse(), .chan_b_gain_fine());
	nccr_host host_u (.clock(clock), .sdio_wire(sdio_w), .sclk(sclk),
		.cs_n(cs_n), .sdo(hsdo), .done(done), .rdata(rdata));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.frame(1'b1, a, 8'h00, 16);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host_u.frame(1'b0, a, d, 16);
		if (a >= 5'h05 && a <= 5'h0E)
			img[a] = d;
	endtask
	// every output field against the register image
	task automatic fields();
		logic [15:0] f;
		logic [15:0] p;
		f = {img[6], img[5]};
		p = {img[8], img[7]};
		if (lp)
			{f[10:0], p[10:0]} = 22'h0;
		`CHK(dut_u.osc_frequency_word_hi, f)
		`CHK(dut_u.osc_phase_word, p)
		`CHK({dut_u.chan_a_power_off, dut_u.chan_a_sleep}, img[9][7:6])
		`CHK({dut_u.chan_b_power_off, dut_u.chan_b_sleep}, img[12][7:6])
		`CHK(dut_u.chan_a_offset, {img[11][5:0], img[9][5:0]})
		`CHK(dut_u.chan_a_gain_coarse, {img[11][7:6], img[10][7:6]})
		`CHK(dut_u.chan_a_gain_fine, img[10][5:0])
		`CHK(dut_u.chan_b_offset, {img[14][5:0], img[12][5:0]})
		`CHK(dut_u.chan_b_gain_coarse, {img[14][7:6], img[13][7:6]})
		`CHK(dut_u.chan_b_gain_fine, img[13][5:0])
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// read results are matched against the oldest expectation
	always @(posedge clock)
	begin
		if (done === 1'b1)
		begin
			e_v = exp_q.pop_front();
			`CHK(rdata, e_v)
		end
	end
	initial
	begin
		{rst_n, lp, failures, tests_run} = 0;
		void'($urandom(32'hF36B4E53));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		for (int a = 5; a <= 14; a++)
		begin
			img[a] = 8'h00;
			rd(5'(a), 8'h00);
		end
		rd(5'h1F, 8'h00);
		fields();
		$display("test reset_values done");
		// two rounds, each with writes outside the range that must vanish
		repeat (2)
		begin
			for (int a = 5; a <= 14; a++)
				wr(5'(a), 8'($urandom));
			wr(5'h10, 8'($urandom));
			wr(5'h1F, 8'($urandom));
			for (int a = 5; a <= 14; a++)
				rd(5'(a), img[a]);
			fields();
		end
		$display("test write_readback done");
		// a frame cut after twelve bits must leave the register untouched
		host_u.frame(1'b0, 5'h09, ~img[9], 12);
		rd(5'h09, img[9]);
		rd(5'h10, 8'h00);
		rd(5'h1F, 8'h00);
		fields();
		$display("test cut_frame done");
		lp <= 1'b1;
		repeat (3) @(posedge clock);
		fields();
		lp <= 1'b0;
		repeat (3) @(posedge clock);
		fields();
		$display("test low_power done");
		// reset in mid-run clears every register again
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		for (int a = 5; a <= 14; a++)
			img[a] = 8'h00;
		fields();
		rd(5'h0E, 8'h00);
		$display("test mid_reset done");
		repeat (4) @(posedge clock);
		conclude();
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		failures++;
		conclude();
	end
endmodule
